// [dpsp_memory.sv]
// Top of the dual-port synchronous parity memory
`timescale 1ns/10ps
`include "dpsp_defines.svh"

module dpsp_memory
   import dpsp_pkg::*;
#(
   parameter int DEPTH   = `DPSP_DEPTH,
   parameter int INDEX_W = `DPSP_INDEX_W
)
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [INDEX_W-1:0]      word_index,
   input  wire logic                    select_low_n,
   input  wire logic                    select_high,
   input  wire logic                    write_strobe_n,
   input  wire logic                    cpu_capture_gate_n,
   input  wire logic                    sys_capture_gate_n,
   input  wire logic                    cpu_drive_gate_n,
   input  wire logic                    sys_drive_gate_n,
   input  wire logic [`DPSP_DATA_W-1:0] cpu_bus_bits_in,
   output logic      [`DPSP_DATA_W-1:0] cpu_bus_bits_out,
   output logic                         cpu_bus_bits_oe,
   input  wire logic                    cpu_bus_check_bit_in,
   output logic                         cpu_bus_check_bit_out,
   output logic                         cpu_bus_check_bit_oe,
   input  wire logic [`DPSP_DATA_W-1:0] sys_bus_bits_in,
   output logic      [`DPSP_DATA_W-1:0] sys_bus_bits_out,
   output logic                         sys_bus_bits_oe,
   input  wire logic                    sys_bus_check_bit_in,
   output logic                         sys_bus_check_bit_out,
   output logic                         sys_bus_check_bit_oe,
   output logic                         parity_fault_flag_pd_n,
   output dpsp_cycle_t                  cycle_kind_r
);

   // ==========================================================================
   // Declarations

   // Falling-edge stage
   logic [INDEX_W-1:0] index_r;
   logic [INDEX_W-1:0] index_nxt;
   logic               sel_r;
   logic               sel_nxt;

   // Word storage
   dpsp_word_t array_mem [DEPTH];
   dpsp_word_t array_rd;
   logic       array_we;

   // Pin words as seen this edge
   dpsp_word_t cpu_pin_word;
   dpsp_word_t sys_pin_word;
   dpsp_word_t cpu_out_word;
   dpsp_word_t sys_out_word;
   logic       cpu_oe;
   logic       sys_oe;

   // Decode and internal bus
   dpsp_cycle_t cyc;
   dpsp_cycle_t cycle_kind_nxt;
   dpsp_word_t  int_bus;
   logic        cpu_load;
   logic        sys_load;
   logic        cpu_allow;
   logic        sys_allow;
   logic        read_check;

   // ==========================================================================
   // Word index and selects: next value
   always_comb begin
      index_nxt = word_index;
      sel_nxt   = ~select_low_n & select_high;
      if (rst) begin
         index_nxt = `DPSP_INDEX_RST;
         sel_nxt   = 1'b0;
      end
   end

   // Word index and selects: taken on the falling edge
   always_ff @(negedge clk) begin
      index_r <= index_nxt;
      sel_r   <= sel_nxt;
   end

   // ==========================================================================
   // Pin words gathered from the bit and check-bit pins
   assign cpu_pin_word = {cpu_bus_check_bit_in, cpu_bus_bits_in};
   assign sys_pin_word = {sys_bus_check_bit_in, sys_bus_bits_in};

   // Array content at the held word index
   assign array_rd = array_mem[index_r];

   // ==========================================================================
   // Cycle decode from controls present at the rising edge
   always_comb begin
      cyc = dpsp_decode(sel_r,
                        write_strobe_n,
                        cpu_capture_gate_n,
                        sys_capture_gate_n,
                        cpu_drive_gate_n,
                        sys_drive_gate_n);
   end

   // ==========================================================================
   // Internal bus source, latch loads and port drive permission
   always_comb begin
      int_bus    = array_rd;
      cpu_load   = 1'b0;
      sys_load   = 1'b0;
      cpu_allow  = 1'b0;
      sys_allow  = 1'b0;
      read_check = 1'b0;
      array_we   = 1'b0;
      unique case (cyc)
         cyc_read: begin
            int_bus    = array_rd;
            cpu_load   = 1'b1;
            sys_load   = 1'b1;
            cpu_allow  = 1'b1;
            sys_allow  = 1'b1;
            read_check = 1'b1;
         end
         cyc_cpu_write: begin
            int_bus   = cpu_pin_word;
            array_we  = 1'b1;
            sys_load  = 1'b1;
            sys_allow = 1'b1;
         end
         cyc_sys_write: begin
            int_bus   = sys_pin_word;
            array_we  = 1'b1;
            cpu_load  = 1'b1;
            cpu_allow = 1'b1;
         end
         cyc_cpu_pass: begin
            int_bus   = cpu_pin_word;
            sys_load  = 1'b1;
            sys_allow = 1'b1;
         end
         cyc_sys_pass: begin
            int_bus   = sys_pin_word;
            cpu_load  = 1'b1;
            cpu_allow = 1'b1;
         end
         cyc_idle: begin
            int_bus = array_rd;
         end
      endcase
   end

   // ==========================================================================
   // Array write: committed on the rising edge, no further strobe needed
   always_ff @(posedge clk) begin
      if (array_we && !rst) begin
         array_mem[index_r] <= int_bus;
      end
   end

   // ==========================================================================
   // Cycle kind report: next value and register
   always_comb begin
      cycle_kind_nxt = cyc;
      if (rst) begin
         cycle_kind_nxt = cyc_idle;
      end
   end

   always_ff @(posedge clk) begin
      cycle_kind_r <= cycle_kind_nxt;
   end

   // ==========================================================================
   // Processor-side port; a captured port is never allowed to drive
   dpsp_port u_cpu_port (
      .clk          (clk),
      .rst          (rst),
      .pin_word_in  (cpu_pin_word),
      .latch_load   (cpu_load),
      .latch_word   (int_bus),
      .drive_allow  (cpu_allow),
      .drive_gate_n (cpu_drive_gate_n),
      .word_in_r    (),
      .pin_word_out (cpu_out_word),
      .pin_oe       (cpu_oe)
   );

   // System-side port
   dpsp_port u_sys_port (
      .clk          (clk),
      .rst          (rst),
      .pin_word_in  (sys_pin_word),
      .latch_load   (sys_load),
      .latch_word   (int_bus),
      .drive_allow  (sys_allow),
      .drive_gate_n (sys_drive_gate_n),
      .word_in_r    (),
      .pin_word_out (sys_out_word),
      .pin_oe       (sys_oe)
   );

   // ==========================================================================
   // Parity checker, judged one clock after the read
   dpsp_parity u_parity (
      .clk        (clk),
      .rst        (rst),
      .check_en   (read_check),
      .bus_word   (int_bus),
      .selected   (sel_r),
      .fault_pd_n (parity_fault_flag_pd_n)
   );

   // ==========================================================================
   // Pin outputs split back into bit and check-bit groups
   assign cpu_bus_bits_out      = cpu_out_word[`DPSP_DATA_W-1:0];
   assign cpu_bus_check_bit_out = cpu_out_word[`DPSP_CHECK_POS];
   assign cpu_bus_bits_oe       = cpu_oe;
   assign cpu_bus_check_bit_oe  = cpu_oe;
   assign sys_bus_bits_out      = sys_out_word[`DPSP_DATA_W-1:0];
   assign sys_bus_check_bit_out = sys_out_word[`DPSP_CHECK_POS];
   assign sys_bus_bits_oe       = sys_oe;
   assign sys_bus_check_bit_oe  = sys_oe;

endmodule

// [dpsp_defines.svh]
// Constants for the dual-port synchronous parity memory
// ==========================================================================
// How it works
// - 32768 words of nine bits each
// - Word index and selects taken on falling edge
// - Write strobe and capture gates taken rising
// - Array write finishes inside one clock
// - Every data pin registered on rising edge
// - Output latch loads on rising edge, holds all cycle
// - Drive gates float their port without clock
// - Deselected means standby, floating, flag one
// - Read drives every port whose gate low
// - Odd parity checked on each read still selected one clock later
// - Parity result shows one clock later
// - Strobe low with one capture gate low writes that port
// - Captured port stays floating, gate ignored
// - Captured word passes to other port latch
// - Streaming works with or without array write
// - Listed idle cases do nothing, flag one
// - Flag one when check bit equals xnor
`ifndef DPSP_DEFINES_SVH
`define DPSP_DEFINES_SVH

// ==========================================================================
// Array shape
`define DPSP_DEPTH        32768
`define DPSP_INDEX_W      15
`define DPSP_DATA_W       8
`define DPSP_WORD_W       9
`define DPSP_CHECK_POS    8

// ==========================================================================
// Reset values and timing
`define DPSP_FAULT_IDLE   1'b1
`define DPSP_INDEX_RST    15'h0000
`define DPSP_WORD_RST     9'h000
`define DPSP_CLK_NS       4

`endif

// [dpsp_pkg.sv]
// Types and shared decode for the dual-port synchronous parity memory
`include "dpsp_defines.svh"

package dpsp_pkg;

   // ==========================================================================
   // Types
   typedef logic [`DPSP_WORD_W-1:0] dpsp_word_t;

   typedef enum logic [2:0] {
      cyc_idle,
      cyc_read,
      cyc_cpu_write,
      cyc_sys_write,
      cyc_cpu_pass,
      cyc_sys_pass
   } dpsp_cycle_t;

   // ==========================================================================
   // Check bit matches inverted xor of data bits
   function automatic logic dpsp_parity_ok(input dpsp_word_t w);
      return w[`DPSP_CHECK_POS] == ~(^w[`DPSP_DATA_W-1:0]);
   endfunction

   // Cycle kind from the sampled controls
   function automatic dpsp_cycle_t dpsp_decode(input logic sel,
                                               input logic wr_n,
                                               input logic cpu_cap_n,
                                               input logic sys_cap_n,
                                               input logic cpu_drv_n,
                                               input logic sys_drv_n);
      dpsp_cycle_t c;
      c = cyc_idle;
      if (!sel) begin
         c = cyc_idle;
      end else if (!cpu_cap_n && sys_cap_n) begin
         c = wr_n ? cyc_cpu_pass : cyc_cpu_write;
      end else if (cpu_cap_n && !sys_cap_n) begin
         c = wr_n ? cyc_sys_pass : cyc_sys_write;
      end else if (cpu_cap_n && sys_cap_n && wr_n && !(cpu_drv_n && sys_drv_n)) begin
         c = cyc_read;
      end
      return c;
   endfunction

endpackage

// [dpsp_port.sv]
// One data port: input register, clocked output latch, drive gating
`timescale 1ns/10ps
`include "dpsp_defines.svh"

module dpsp_port
   import dpsp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire dpsp_word_t pin_word_in,
   input  wire logic       latch_load,
   input  wire dpsp_word_t latch_word,
   input  wire logic       drive_allow,
   input  wire logic       drive_gate_n,
   output dpsp_word_t      word_in_r,
   output dpsp_word_t      pin_word_out,
   output logic            pin_oe
);

   dpsp_word_t word_in_nxt;
   dpsp_word_t latch_r;
   dpsp_word_t latch_nxt;
   logic       allow_r;
   logic       allow_nxt;

   // ==========================================================================
   // Next values: pins captured every edge, latch only when loaded
   always_comb begin
      word_in_nxt = pin_word_in;
      latch_nxt   = latch_load ? latch_word : latch_r;
      allow_nxt   = drive_allow;
      if (rst) begin
         word_in_nxt = `DPSP_WORD_RST;
         latch_nxt   = `DPSP_WORD_RST;
         allow_nxt   = 1'b0;
      end
   end

   // Registers; latch loads on the rising edge and holds until the next rising edge
   always_ff @(posedge clk) begin
      word_in_r <= word_in_nxt;
      latch_r   <= latch_nxt;
      allow_r   <= allow_nxt;
   end

   // Drive gate acts at once, without waiting for a clock edge
   assign pin_word_out = latch_r;
   assign pin_oe       = allow_r & ~drive_gate_n;

endmodule

// [dpsp_parity.sv]
// Delayed odd parity checker with open-drain style fault output
`timescale 1ns/10ps
`include "dpsp_defines.svh"

module dpsp_parity
   import dpsp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       check_en,
   input  wire dpsp_word_t bus_word,
   input  wire logic       selected,
   output logic            fault_pd_n
);

   logic       pend_r;
   logic       pend_nxt;
   dpsp_word_t word_r;
   dpsp_word_t word_nxt;
   logic       fault_nxt;

   // ==========================================================================
   // Stage the read word, then judge it on the following edge
   always_comb begin
      pend_nxt  = check_en;
      word_nxt  = bus_word;
      fault_nxt = `DPSP_FAULT_IDLE;
      if (pend_r && selected) begin
         fault_nxt = dpsp_parity_ok(word_r);
      end
      if (rst) begin
         pend_nxt  = 1'b0;
         word_nxt  = `DPSP_WORD_RST;
         fault_nxt = `DPSP_FAULT_IDLE;
      end
   end

   // Result lands one clock after the read
   always_ff @(posedge clk) begin
      pend_r     <= pend_nxt;
      word_r     <= word_nxt;
      fault_pd_n <= fault_nxt;
   end

endmodule

// [dpsp_memory_props.sv]
// Port timing checker for the dual-port parity memory
`timescale 1ns/10ps
`include "dpsp_defines.svh"

// ==========================================================================
// Checker
module dpsp_memory_chk
   import dpsp_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic                    select_low_n,
   input wire logic                    select_high,
   input wire logic                    write_strobe_n,
   input wire logic                    cpu_capture_gate_n,
   input wire logic                    sys_capture_gate_n,
   input wire logic                    cpu_drive_gate_n,
   input wire logic                    sys_drive_gate_n,
   input wire logic [`DPSP_DATA_W-1:0] cpu_bus_bits_in,
   input wire logic                    cpu_bus_check_bit_in,
   input wire logic [`DPSP_DATA_W-1:0] cpu_bus_bits_out,
   input wire logic                    cpu_bus_bits_oe,
   input wire logic                    cpu_bus_check_bit_out,
   input wire logic                    cpu_bus_check_bit_oe,
   input wire logic [`DPSP_DATA_W-1:0] sys_bus_bits_out,
   input wire logic                    sys_bus_bits_oe,
   input wire logic                    sys_bus_check_bit_out,
   input wire logic                    parity_fault_flag_pd_n,
   input wire dpsp_cycle_t             cycle_kind_r
);
   logic sel_r;
   logic sel_nxt;

   // Select as the device takes it on the falling edge
   always_comb sel_nxt = !select_low_n && select_high;
   always_ff @(negedge clk) sel_r <= sel_nxt;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   chk_desel_idle: assert property (!sel_r |=> cycle_kind_r == cyc_idle)
      else $error("deselected cycle not idle");
   chk_desel_flag: assert property (!sel_r |=> parity_fault_flag_pd_n)
      else $error("deselected but fault flag low");
   chk_flag_idle: assert property (cycle_kind_r != cyc_read |=> parity_fault_flag_pd_n)
      else $error("fault flag low after a non-read cycle");
   chk_capture_float: assert property (
      (!cpu_capture_gate_n |=> !cpu_bus_bits_oe) and
      (!sys_capture_gate_n |=> !sys_bus_bits_oe))
      else $error("captured port drives its pins");
   chk_gate_float: assert property (cpu_drive_gate_n |-> !cpu_bus_bits_oe && !cpu_bus_check_bit_oe)
      else $error("port drives with gate high");
   chk_read_kind: assert property (
      sel_r && write_strobe_n && cpu_capture_gate_n && sys_capture_gate_n &&
      !(cpu_drive_gate_n && sys_drive_gate_n) |=> cycle_kind_r == cyc_read)
      else $error("read cycle not decoded");
   chk_both_idle: assert property (
      sel_r && !cpu_capture_gate_n && !sys_capture_gate_n |=> cycle_kind_r == cyc_idle)
      else $error("double capture not idle");
   chk_write_kind: assert property (
      sel_r && !write_strobe_n && !cpu_capture_gate_n && sys_capture_gate_n
      |=> cycle_kind_r == cyc_cpu_write)
      else $error("cpu write not decoded");
   chk_stream_word: assert property (
      sel_r && !cpu_capture_gate_n && sys_capture_gate_n |=>
      sys_bus_bits_out == $past(cpu_bus_bits_in) &&
      sys_bus_check_bit_out == $past(cpu_bus_check_bit_in))
      else $error("streamed word wrong at system latch");
   chk_fault_delay: assert property (
      cycle_kind_r == cyc_read && sel_r |=>
      parity_fault_flag_pd_n == ($past(cpu_bus_check_bit_out) == ~^$past(cpu_bus_bits_out)))
      else $error("fault flag wrong one clock after read");

   // Main scenarios
   cov_read: cover property (cycle_kind_r == cyc_read);
   cov_fault: cover property ($fell(parity_fault_flag_pd_n));
   cov_stream: cover property (cycle_kind_r == cyc_cpu_write && sys_bus_bits_oe);
   cov_pass: cover property (cycle_kind_r == cyc_sys_pass && cpu_bus_bits_oe);
endmodule

bind dpsp_memory dpsp_memory_chk u_chk (.clk, .rst, .select_low_n, .select_high,
   .write_strobe_n, .cpu_capture_gate_n, .sys_capture_gate_n, .cpu_drive_gate_n,
   .sys_drive_gate_n, .cpu_bus_bits_in, .cpu_bus_check_bit_in, .cpu_bus_bits_out,
   .cpu_bus_bits_oe, .cpu_bus_check_bit_out, .cpu_bus_check_bit_oe, .sys_bus_bits_out,
   .sys_bus_bits_oe, .sys_bus_check_bit_out, .parity_fault_flag_pd_n, .cycle_kind_r);

// [dpsp_bus_end.sv]
// Bus master model at one data port, resolving the shared wire
`timescale 1ns/10ps

// ==========================================================================
// Bus end
module dpsp_bus_end
   import dpsp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       drive_en,
   input  wire dpsp_word_t drive_word,
   input  wire dpsp_word_t dev_word,
   input  wire logic       dev_oe,
   output dpsp_word_t      wire_word,
   output logic            clash
);
   dpsp_word_t last_r = '0;

   // Master drives only while capturing; a free wire shows no stale value
   always_comb begin
      if (dev_oe) wire_word = dev_word;
      else if (drive_en) wire_word = drive_word;
      else wire_word = ~last_r;
      clash = dev_oe && drive_en;
   end
   always_ff @(posedge clk) last_r <= wire_word;
endmodule

// [tb_dual_port_sync_sram_parity.sv]
// Self-checking bench for the dual-port parity memory
`timescale 1ns/10ps

module tb_dual_port_sync_sram_parity;
   import dpsp_pkg::*;
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", n, e, s); end end

   // ==========================================================================
   // Signals
   logic clk, rst, select_low_n, select_high, write_strobe_n;
   logic cpu_capture_gate_n, sys_capture_gate_n, cpu_drive_gate_n, sys_drive_gate_n;
   logic [14:0] word_index;
   logic [7:0] cpu_bus_bits_out, sys_bus_bits_out;
   logic cpu_bus_bits_oe, cpu_bus_check_bit_out, cpu_bus_check_bit_oe;
   logic sys_bus_bits_oe, sys_bus_check_bit_out, sys_bus_check_bit_oe;
   logic parity_fault_flag_pd_n, c_clash, s_clash, pend;
   dpsp_cycle_t cycle_kind_r;
   dpsp_word_t cpu_m, sys_m, cpu_w, sys_w;
   dpsp_word_t ref_mem [int];
   int fail_count = 0;
   int n_compared = 0;
   int cyc_n = 0;
   logic [31:0] r;
   logic [4:0] tbl [12] = '{5'h1d, 5'h1e, 5'h1c, 5'h1f, 5'h03, 5'h07, 5'h0b, 5'h06,
                             5'h09, 5'h16, 5'h19, 5'h0f};

   dpsp_memory dut (.clk, .rst, .word_index, .select_low_n, .select_high, .write_strobe_n,
      .cpu_capture_gate_n, .sys_capture_gate_n, .cpu_drive_gate_n, .sys_drive_gate_n,
      .cpu_bus_bits_in(cpu_w[7:0]), .cpu_bus_bits_out, .cpu_bus_bits_oe,
      .cpu_bus_check_bit_in(cpu_w[8]), .cpu_bus_check_bit_out, .cpu_bus_check_bit_oe,
      .sys_bus_bits_in(sys_w[7:0]), .sys_bus_bits_out, .sys_bus_bits_oe,
      .sys_bus_check_bit_in(sys_w[8]), .sys_bus_check_bit_out, .sys_bus_check_bit_oe,
      .parity_fault_flag_pd_n, .cycle_kind_r);
   dpsp_bus_end u_cpu (.clk, .drive_en(!cpu_capture_gate_n), .drive_word(cpu_m),
      .dev_word({cpu_bus_check_bit_out, cpu_bus_bits_out}), .dev_oe(cpu_bus_bits_oe),
      .wire_word(cpu_w), .clash(c_clash));
   dpsp_bus_end u_sys (.clk, .drive_en(!sys_capture_gate_n), .drive_word(sys_m),
      .dev_word({sys_bus_check_bit_out, sys_bus_bits_out}), .dev_oe(sys_bus_bits_oe),
      .wire_word(sys_w), .clash(s_clash));

   // ==========================================================================
   // Clock, timeout and helpers
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 2000) begin
         fail_count++;
         summarize();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic podd(input dpsp_word_t w);
      return w[8] == ~^w[7:0];
   endfunction
   // Expected cycle kind from the controls now applied
   function automatic dpsp_cycle_t kd();
      if (select_low_n || !select_high) return cyc_idle;
      if (!cpu_capture_gate_n && sys_capture_gate_n)
         return write_strobe_n ? cyc_cpu_pass : cyc_cpu_write;
      if (cpu_capture_gate_n && !sys_capture_gate_n)
         return write_strobe_n ? cyc_sys_pass : cyc_sys_write;
      if (cpu_capture_gate_n && sys_capture_gate_n && write_strobe_n &&
          !(cpu_drive_gate_n && sys_drive_gate_n)) return cyc_read;
      return cyc_idle;
   endfunction
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Outputs at rest straight after reset
   task automatic rest_chk();
      `CHK("rest kind", cyc_idle, cycle_kind_r)
      `CHK("rest oe", 2'b00, {cpu_bus_bits_oe, sys_bus_bits_oe})
      `CHK("rest flag", 1'b1, parity_fault_flag_pd_n)
   endtask

   // One cycle: apply index, controls and data, check outputs after the rising edge
   task automatic go(input logic [14:0] i, input logic [4:0] m, input logic [17:0] d);
      dpsp_cycle_t k;
      dpsp_word_t w;
      logic ce, se, sel;
      word_index = i;
      {write_strobe_n, cpu_capture_gate_n, sys_capture_gate_n,
       cpu_drive_gate_n, sys_drive_gate_n} = m;
      {cpu_m, sys_m} = d;
      k = kd();
      sel = !select_low_n && select_high;
      ce = 1'b0;
      se = 1'b0;
      w = '0;
      case (k)
         cyc_read: begin
            w = ref_mem[i];
            ce = !cpu_drive_gate_n;
            se = !sys_drive_gate_n;
         end
         cyc_cpu_write, cyc_cpu_pass: begin
            w = cpu_m;
            se = !sys_drive_gate_n;
         end
         cyc_sys_write, cyc_sys_pass: begin
            w = sys_m;
            ce = !cpu_drive_gate_n;
         end
         default: ;
      endcase
      @(posedge clk);
      #1;
      `CHK("kind", k, cycle_kind_r)
      `CHK("fault", sel ? pend : 1'b1, parity_fault_flag_pd_n)
      `CHK("cpu oe", {ce, ce}, {cpu_bus_bits_oe, cpu_bus_check_bit_oe})
      `CHK("sys oe", {se, se}, {sys_bus_bits_oe, sys_bus_check_bit_oe})
      if (ce) `CHK("cpu word", w, {cpu_bus_check_bit_out, cpu_bus_bits_out})
      if (se) `CHK("sys word", w, {sys_bus_check_bit_out, sys_bus_bits_out})
      `CHK("clash", 2'b00, {c_clash, s_clash})
      if (k == cyc_cpu_write) ref_mem[i] = cpu_m;
      if (k == cyc_sys_write) ref_mem[i] = sys_m;
      pend = (k == cyc_read) ? podd(w) : 1'b1;
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      {select_low_n, select_high, write_strobe_n} = 3'h6;
      {cpu_capture_gate_n, sys_capture_gate_n, cpu_drive_gate_n, sys_drive_gate_n} = 4'hf;
      word_index = 15'h0000;
      {cpu_m, sys_m} = 18'h00000;
      pend = 1'b1;
      r = 32'h000175c5;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      rest_chk();
      select_low_n = 1'b0;
      select_high = 1'b1;
      // Fill every used word, parity good on words 2, 3, 4 and 7fff, bad on the rest
      for (int i = 0; i < 9; i++)
         go((i == 8) ? 15'h7fff : 15'(i), 5'h07, {9'(i * 37) ^ {i[0], 8'h00}, 9'h000});
      // Dual bus reads back to back
      for (int i = 0; i < 9; i++) go((i == 8) ? 15'h7fff : 15'(i), 5'h1c, 18'h00000);
      // Drive gate floats the port without a clock
      cpu_drive_gate_n = 1'b1;
      #0.5;
      `CHK("gate float", 1'b0, cpu_bus_bits_oe)
      // Back onto the usual stimulus offset; this extra cycle rereads the same word
      @(posedge clk);
      #1;
      // Every listed control combination once
      for (int i = 0; i < 12; i++) go(15'(i % 8), tbl[i], 18'h2a5c3);
      // Random cycles with occasional standby
      for (int n = 0; n < 300; n++) begin
         r = lfsr(r);
         select_low_n = (r[7:4] == 4'h1);
         select_high = (r[7:4] != 4'h0);
         go({12'h000, r[2:0]}, tbl[r[31:26] % 12], r[25:8]);
      end
      // Mid-run reset: outputs return to rest, array keeps its words
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      rest_chk();
      pend = 1'b1;
      select_low_n = 1'b0;
      select_high = 1'b1;
      for (int i = 0; i < 8; i++) go(15'(i), 5'h1c, 18'h00000);
      summarize();
   end
endmodule
